// ===== core/urie_pkg.sv
// constants shared by the uart register map and interrupt enable block
package urie_pkg;

	// ----------------------------------------------------------------
	// register addresses, normal bank
	// ----------------------------------------------------------------
	localparam logic [2:0] A_HOLD   = 3'h0;
	localparam logic [2:0] A_MASK   = 3'h1;
	localparam logic [2:0] A_SRC    = 3'h2;
	localparam logic [2:0] A_LINE   = 3'h3;
	localparam logic [2:0] A_MODEM  = 3'h4;
	localparam logic [2:0] A_STATE  = 3'h5;
	localparam logic [2:0] A_MSTAT  = 3'h6;
	localparam logic [2:0] A_SCR    = 3'h7;
	// divisor bank and enhanced bank
	localparam logic [2:0] A_DIV_LO = 3'h0;
	localparam logic [2:0] A_DIV_HI = 3'h1;
	localparam logic [2:0] A_ALT    = 3'h2;
	localparam logic [2:0] A_TRIG   = 3'h0;
	localparam logic [2:0] A_FEAT   = 3'h1;
	localparam logic [2:0] A_ENH    = 3'h2;

	// ----------------------------------------------------------------
	// field positions and keys
	// ----------------------------------------------------------------
	localparam logic [7:0] LCR_ENH_KEY = 8'hBF;
	localparam int         LCR_DIV_BIT = 7;
	localparam int         EFR_ENH_BIT = 4;
	localparam int         IE_RX       = 0;
	localparam int         IE_TX       = 1;
	localparam int         IE_LS       = 2;
	localparam int         IE_MS       = 3;
	localparam int         IE_SLEEP    = 4;
	localparam logic [7:0] IER_GATED   = 8'hF0;
	localparam logic [7:0] FCR_GATED   = 8'h30;
	localparam logic [7:0] MCR_GATED   = 8'hE0;
	localparam int         FCR_EN      = 0;
	localparam int         FCR_RXRST   = 1;
	localparam int         FCR_TXRST   = 2;
	localparam int         LS_DR       = 0;
	localparam int         LS_OE       = 1;
	localparam int         LS_THRE     = 5;
	localparam int         LS_TEMT     = 6;
	localparam int         LS_FERR     = 7;
	localparam logic [7:0] REG_RST     = 8'h00;
	localparam logic [1:0] FIFO_ON     = 2'h3;

	// ----------------------------------------------------------------
	// interrupt source codes, bits 5:0 of the source register
	// ----------------------------------------------------------------
	localparam logic [5:0] ISR_LS   = 6'h06;
	localparam logic [5:0] ISR_RX   = 6'h04;
	localparam logic [5:0] ISR_TX   = 6'h02;
	localparam logic [5:0] ISR_MS   = 6'h00;
	localparam logic [5:0] ISR_NONE = 6'h01;

	typedef enum {
		REG_NONE, REG_HOLD, REG_MASK, REG_SRC, REG_LINE, REG_MODEM, REG_STATE,
		REG_MSTAT, REG_SCR, REG_DIV_LO, REG_DIV_HI, REG_ALT, REG_REV, REG_IDENT,
		REG_TRIG, REG_FEAT, REG_ENH, REG_CHAR
	} urie_reg_t;

endpackage

// ===== core/urie_buf2.sv
// two-entry buffer between the host write port and the transmitter
`timescale 1ns/10ps
`default_nettype none

module urie_buf2 #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// filling side
	input  wire logic         in_valid_in,
	input  wire logic [W-1:0] in_data_in,
	output logic              in_ready_out,
	// draining side
	output logic              out_valid_out,
	output logic [W-1:0]      out_data_out,
	input  wire logic         out_ready_in,
	// status
	output logic              empty_out
);

	logic [W-1:0] slot_r   [2];
	logic [W-1:0] slot_nxt [2];
	logic         head_r;
	logic         head_nxt;
	logic [1:0]   cnt_r;
	logic [1:0]   cnt_nxt;
	logic         push;
	logic         pop;

	assign in_ready_out  = (cnt_r != 2'h2);
	assign out_valid_out = (cnt_r != 2'h0);
	assign empty_out     = (cnt_r == 2'h0);
	assign out_data_out  = slot_r[head_r];

	always_comb begin
		push        = in_valid_in && in_ready_out;
		pop         = out_valid_out && out_ready_in;
		slot_nxt[0] = slot_r[0];
		slot_nxt[1] = slot_r[1];
		head_nxt    = head_r ^ pop;
		cnt_nxt     = cnt_r + {1'b0, push} - {1'b0, pop};
		if (push) begin
			slot_nxt[head_r ^ cnt_r[0]] = in_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			slot_r[0] <= '0;
			slot_r[1] <= '0;
			head_r    <= 1'b0;
			cnt_r     <= 2'h0;
		end else begin
			slot_r[0] <= slot_nxt[0];
			slot_r[1] <= slot_nxt[1];
			head_r    <= head_nxt;
			cnt_r     <= cnt_nxt;
		end
	end

endmodule

`default_nettype wire

// ===== core/urie_regmap.sv
// uart channel register map with interrupt enable and line state logic
`timescale 1ns/10ps
`default_nettype none

module urie_regmap
	import urie_pkg::*;
#(
	parameter logic [7:0] REV_CODE = 8'h01, // arbitrary value
	parameter logic [7:0] ID_CODE  = 8'h5A, // arbitrary value
	parameter int         CW       = 7
) (
	// clock and reset
	input  wire logic          clk_in,
	input  wire logic          rst_in,
	// host register port
	input  wire logic [2:0]    addr_in,
	input  wire logic          wr_stb_in,
	input  wire logic          rd_stb_in,
	input  wire logic [7:0]    wr_data_in,
	output logic [7:0]         rd_data_out,
	output logic               rd_valid_out,
	output logic               thr_ready_out,
	// receiver side
	input  wire logic [7:0]    rx_data_in,
	input  wire logic [CW-1:0] rx_count_in,
	input  wire logic          rx_push_in,
	input  wire logic [3:0]    rx_push_err_in,
	input  wire logic [2:0]    rx_head_err_in,
	input  wire logic          rx_any_err_in,
	output logic               rx_pop_out,
	// transmitter side
	output logic [7:0]         tx_data_out,
	output logic               tx_valid_out,
	input  wire logic          tx_ready_in,
	input  wire logic [CW-1:0] tx_count_in,
	input  wire logic          tx_shift_empty_in,
	// modem status
	input  wire logic [7:0]    modem_status_in,
	output logic               msr_read_out,
	// interrupt
	output logic               irq_out,
	// configuration towards the datapaths
	output logic [7:0]         line_control_out,
	output logic [15:0]        divisor_out,
	output logic [7:0]         queue_control_out,
	output logic [7:0]         modem_control_out,
	output logic [7:0]         enhanced_function_out,
	output logic [7:0]         feature_control_out,
	output logic [7:0]         alt_function_out,
	output logic [7:0]         trigger_level_out,
	output logic [31:0]        flow_chars_out,
	output logic               sleep_enable_out,
	output logic               rx_fifo_reset_out,
	output logic               tx_fifo_reset_out
);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic urie_reg_t reg_sel(input logic [7:0] line_control, input logic [2:0] a,
		input logic rd, input logic div_zero);
		urie_reg_t r;
		r = REG_NONE;
		if (line_control == LCR_ENH_KEY) begin
			case (a)
				A_TRIG:  r = REG_TRIG;
				A_FEAT:  r = REG_FEAT;
				A_ENH:   r = REG_ENH;
				A_LINE:  r = REG_LINE;
				default: r = REG_CHAR;
			endcase
		end else if (line_control[LCR_DIV_BIT] && a == A_DIV_LO) begin
			r = (rd && div_zero) ? REG_REV : REG_DIV_LO;
		end else if (line_control[LCR_DIV_BIT] && a == A_DIV_HI) begin
			r = (rd && div_zero) ? REG_IDENT : REG_DIV_HI;
		end else if (line_control[LCR_DIV_BIT] && a == A_ALT) begin
			r = REG_ALT;
		end else begin
			case (a)
				A_HOLD:  r = REG_HOLD;
				A_MASK:  r = REG_MASK;
				A_SRC:   r = REG_SRC;
				A_LINE:  r = REG_LINE;
				A_MODEM: r = REG_MODEM;
				A_STATE: r = REG_STATE;
				A_MSTAT: r = REG_MSTAT;
				default: r = REG_SCR;
			endcase
		end
		return r;
	endfunction

	// a programmed level of zero behaves as one
	function automatic logic [CW-1:0] trig_of(input logic [7:0] t);
		logic [CW-1:0] v;
		v = (t == REG_RST) ? CW'(1) : CW'(t);
		return v;
	endfunction

	// gated bits only move while the enhanced enable is set
	function automatic logic [7:0] gate_wr(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] gm, input logic en);
		logic [7:0] v;
		v = en ? nw : ((old & gm) | (nw & ~gm));
		return v;
	endfunction

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [7:0] lcr_r,  lcr_nxt;
	logic [7:0] ier_r,  ier_nxt;
	logic [7:0] fcr_r,  fcr_nxt;
	logic [7:0] mcr_r,  mcr_nxt;
	logic [7:0] scr_r,  scr_nxt;
	logic [7:0] dlo_r,  dlo_nxt;
	logic [7:0] dhi_r,  dhi_nxt;
	logic [7:0] alt_r,  alt_nxt;
	logic [7:0] trg_r,  trg_nxt;
	logic [7:0] feat_r, feat_nxt;
	logic [7:0] enh_r,  enh_nxt;
	logic [7:0] chr_r   [4];
	logic [7:0] chr_nxt [4];
	logic       rxrst_r, rxrst_nxt;
	logic       txrst_r, txrst_nxt;

	logic       enh_on;
	logic       div_zero;
	urie_reg_t  wsel;
	urie_reg_t  rsel;
	logic       wr_hold;

	assign enh_on   = enh_r[EFR_ENH_BIT];
	assign div_zero = (dlo_r == REG_RST) && (dhi_r == REG_RST);
	assign wsel     = reg_sel(lcr_r, addr_in, 1'b0, div_zero);
	assign rsel     = reg_sel(lcr_r, addr_in, 1'b1, div_zero);
	assign wr_hold  = wr_stb_in && (wsel == REG_HOLD);

	always_comb begin
		lcr_nxt    = lcr_r;
		ier_nxt    = ier_r;
		fcr_nxt    = fcr_r;
		mcr_nxt    = mcr_r;
		scr_nxt    = scr_r;
		dlo_nxt    = dlo_r;
		dhi_nxt    = dhi_r;
		alt_nxt    = alt_r;
		trg_nxt    = trg_r;
		feat_nxt   = feat_r;
		enh_nxt    = enh_r;
		chr_nxt    = chr_r;
		rxrst_nxt  = 1'b0;
		txrst_nxt  = 1'b0;
		if (wr_stb_in) begin
			case (wsel)
				REG_LINE:   lcr_nxt  = wr_data_in;
				REG_MASK:   ier_nxt  = gate_wr(ier_r, wr_data_in, IER_GATED, enh_on);
				REG_MODEM:  mcr_nxt  = gate_wr(mcr_r, wr_data_in, MCR_GATED, enh_on);
				REG_SCR:    scr_nxt  = wr_data_in;
				REG_DIV_LO: dlo_nxt  = wr_data_in;
				REG_DIV_HI: dhi_nxt  = wr_data_in;
				REG_ALT:    alt_nxt  = wr_data_in;
				REG_TRIG:   trg_nxt  = wr_data_in;
				REG_FEAT:   feat_nxt = wr_data_in;
				REG_ENH:    enh_nxt  = wr_data_in;
				REG_CHAR:   chr_nxt[addr_in[1:0]] = wr_data_in;
				REG_SRC: begin
					// other fields only program while the enable bit is written as one
					if (wr_data_in[FCR_EN]) begin
						fcr_nxt = gate_wr(fcr_r, wr_data_in, FCR_GATED, enh_on);
						fcr_nxt[FCR_RXRST] = 1'b0;
						fcr_nxt[FCR_TXRST] = 1'b0;
						rxrst_nxt = wr_data_in[FCR_RXRST];
						txrst_nxt = wr_data_in[FCR_TXRST];
					end else begin
						fcr_nxt[FCR_EN] = 1'b0;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			lcr_r   <= REG_RST;
			ier_r   <= REG_RST;
			fcr_r   <= REG_RST;
			mcr_r   <= REG_RST;
			scr_r   <= REG_RST;
			dlo_r   <= REG_RST;
			dhi_r   <= REG_RST;
			alt_r   <= REG_RST;
			trg_r   <= REG_RST;
			feat_r  <= REG_RST;
			enh_r   <= REG_RST;
			chr_r   <= '{default: REG_RST};
			rxrst_r <= 1'b0;
			txrst_r <= 1'b0;
		end else begin
			lcr_r   <= lcr_nxt;
			ier_r   <= ier_nxt;
			fcr_r   <= fcr_nxt;
			mcr_r   <= mcr_nxt;
			scr_r   <= scr_nxt;
			dlo_r   <= dlo_nxt;
			dhi_r   <= dhi_nxt;
			alt_r   <= alt_nxt;
			trg_r   <= trg_nxt;
			feat_r  <= feat_nxt;
			enh_r   <= enh_nxt;
			chr_r   <= chr_nxt;
			rxrst_r <= rxrst_nxt;
			txrst_r <= txrst_nxt;
		end
	end

	// ----------------------------------------------------------------
	// transmit buffer
	// ----------------------------------------------------------------
	logic buf_empty;

	urie_buf2 #(
		.W (8)
	) u_txbuf (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (wr_hold),
		.in_data_in    (wr_data_in),
		.in_ready_out  (thr_ready_out),
		.out_valid_out (tx_valid_out),
		.out_data_out  (tx_data_out),
		.out_ready_in  (tx_ready_in),
		.empty_out     (buf_empty)
	);

	// ----------------------------------------------------------------
	// interrupt conditions and line state
	// ----------------------------------------------------------------
	logic       fifo_mode;
	logic       rx_cond;
	logic       tx_cond;
	logic       thr_empty;
	logic       rd_state;
	logic       rd_src;
	logic [7:0] line_state;
	logic [7:0] interrupt_source_status;
	logic       ovr_r,   ovr_nxt;
	logic       lsp_r,   lsp_nxt;
	logic       txp_r,   txp_nxt;
	logic       txa_q_r, txa_q_nxt;
	logic       txa;

	assign fifo_mode = fcr_r[FCR_EN];
	assign thr_empty = buf_empty && (tx_count_in == '0);
	// fill compared live, so the code and the irq drop together with the fill
	assign rx_cond   = fifo_mode ? (rx_count_in >= trig_of(trg_r))
		: (rx_count_in != '0);
	assign tx_cond   = fifo_mode ? (buf_empty && tx_count_in < trig_of(trg_r))
		: thr_empty;
	assign txa       = ier_r[IE_TX] && tx_cond;
	assign rd_state  = rd_stb_in && (rsel == REG_STATE);
	assign rd_src    = rd_stb_in && (rsel == REG_SRC);

	always_comb begin
		line_state = REG_RST;
		line_state[LS_DR]       = (rx_count_in != '0);
		line_state[LS_OE]       = ovr_r;
		line_state[4:2]         = rx_head_err_in;
		line_state[LS_THRE]     = thr_empty;
		line_state[LS_TEMT]     = thr_empty && tx_shift_empty_in;
		line_state[LS_FERR]     = rx_any_err_in;
	end

	always_comb begin
		// a new event in the clearing cycle wins over the clear
		ovr_nxt   = ovr_r;
		lsp_nxt   = lsp_r;
		txp_nxt   = txp_r;
		txa_q_nxt = txa;
		if (rd_state) begin
			ovr_nxt = 1'b0;
			lsp_nxt = 1'b0;
		end
		if (rd_src || wr_hold) begin
			txp_nxt = 1'b0;
		end
		if (rx_push_in && rx_push_err_in[0]) begin
			ovr_nxt = 1'b1;
		end
		if (rx_push_in && (rx_push_err_in != 4'h0)) begin
			lsp_nxt = 1'b1;
		end
		if (txa && !txa_q_r) begin
			txp_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ovr_r   <= 1'b0;
			lsp_r   <= 1'b0;
			txp_r   <= 1'b0;
			txa_q_r <= 1'b0;
		end else begin
			ovr_r   <= ovr_nxt;
			lsp_r   <= lsp_nxt;
			txp_r   <= txp_nxt;
			txa_q_r <= txa_q_nxt;
		end
	end

	always_comb begin
		interrupt_source_status = REG_RST;
		interrupt_source_status[7:6] = fifo_mode ? FIFO_ON : 2'h0;
		// priority: line, receive, transmit, modem; bits 5:4 are held at zero
		if (ier_r[IE_LS] && lsp_r) begin
			interrupt_source_status[5:0] = ISR_LS;
		end else if (ier_r[IE_RX] && rx_cond) begin
			interrupt_source_status[5:0] = ISR_RX;
		end else if (ier_r[IE_TX] && txp_r) begin
			interrupt_source_status[5:0] = ISR_TX;
		end else if (ier_r[IE_MS] && (modem_status_in[3:0] != 4'h0)) begin
			interrupt_source_status[5:0] = ISR_MS;
		end else begin
			interrupt_source_status[5:0] = ISR_NONE;
		end
	end

	assign irq_out = (interrupt_source_status[5:0] != ISR_NONE);

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	logic [7:0] rd_r, rd_nxt;
	logic       rv_r, rv_nxt;

	always_comb begin
		rd_nxt = rd_r;
		rv_nxt = rd_stb_in;
		if (rd_stb_in) begin
			case (rsel)
				REG_HOLD:   rd_nxt = rx_data_in;
				REG_MASK:   rd_nxt = enh_on ? ier_r : (ier_r & ~IER_GATED);
				REG_SRC:    rd_nxt = interrupt_source_status;
				REG_LINE:   rd_nxt = lcr_r;
				REG_MODEM:  rd_nxt = enh_on ? mcr_r : (mcr_r & ~MCR_GATED);
				REG_STATE:  rd_nxt = line_state;
				REG_MSTAT:  rd_nxt = modem_status_in;
				REG_SCR:    rd_nxt = scr_r;
				REG_DIV_LO: rd_nxt = dlo_r;
				REG_DIV_HI: rd_nxt = dhi_r;
				REG_ALT:    rd_nxt = alt_r;
				REG_REV:    rd_nxt = REV_CODE;
				REG_IDENT:  rd_nxt = ID_CODE;
				// a fill wider than a byte saturates instead of wrapping
				REG_TRIG:   rd_nxt = (rx_count_in > CW'(8'hFF)) ? 8'hFF : 8'(rx_count_in);
				REG_FEAT:   rd_nxt = feat_r;
				REG_ENH:    rd_nxt = enh_r;
				REG_CHAR:   rd_nxt = chr_r[addr_in[1:0]];
				default:    rd_nxt = REG_RST;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_r <= REG_RST;
			rv_r <= 1'b0;
		end else begin
			rd_r <= rd_nxt;
			rv_r <= rv_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign rd_data_out           = rd_r;
	assign rd_valid_out          = rv_r;
	assign rx_pop_out            = rd_stb_in && (rsel == REG_HOLD);
	assign msr_read_out          = rd_stb_in && (rsel == REG_MSTAT);
	assign line_control_out      = lcr_r;
	assign divisor_out           = {dhi_r, dlo_r};
	assign queue_control_out     = enh_on ? fcr_r : (fcr_r & ~FCR_GATED);
	assign modem_control_out     = enh_on ? mcr_r : (mcr_r & ~MCR_GATED);
	assign enhanced_function_out = enh_r;
	assign feature_control_out   = feat_r;
	assign alt_function_out      = alt_r;
	assign trigger_level_out     = trg_r;
	assign flow_chars_out        = {chr_r[3], chr_r[2], chr_r[1], chr_r[0]};
	assign sleep_enable_out      = enh_on && ier_r[IE_SLEEP];
	assign rx_fifo_reset_out     = rxrst_r;
	assign tx_fifo_reset_out     = txrst_r;

endmodule

`default_nettype wire

// ===== tb/urie_regmap_props.sv
// port-level assertions for the uart register map
`timescale 1ns/10ps
`default_nettype none

module urie_regmap_props
	import urie_pkg::*;
#(
	parameter int CW = 7
) (
	// clock and reset
	input wire logic          clk_in,
	input wire logic          rst_in,
	// host port
	input wire logic [2:0]    addr_in,
	input wire logic          wr_stb_in,
	input wire logic          rd_stb_in,
	input wire logic [7:0]    wr_data_in,
	input wire logic [7:0]    rd_data_out,
	input wire logic          rd_valid_out,
	// datapath side
	input wire logic [CW-1:0] rx_count_in,
	input wire logic [2:0]    rx_head_err_in,
	input wire logic          rx_any_err_in,
	input wire logic          rx_pop_out,
	input wire logic [7:0]    tx_data_out,
	input wire logic          tx_valid_out,
	input wire logic          tx_ready_in,
	input wire logic          msr_read_out,
	// configuration
	input wire logic [7:0]    line_control_out,
	input wire logic [15:0]   divisor_out,
	input wire logic [7:0]    queue_control_out,
	input wire logic [7:0]    modem_control_out,
	input wire logic [7:0]    enhanced_function_out,
	input wire logic [31:0]   flow_chars_out,
	input wire logic          sleep_enable_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// divisor bank needs the divide bit without the enhanced key
	logic div_bank;
	assign div_bank = line_control_out[LCR_DIV_BIT] && line_control_out != LCR_ENH_KEY;

	sequence s_state_rd;
		rd_stb_in && addr_in == A_STATE && line_control_out != LCR_ENH_KEY;
	endsequence
	sequence s_div_wr(a);
		wr_stb_in && addr_in == a && div_bank;
	endsequence

	chk_read_answer: assert property (rd_stb_in |=> rd_valid_out)
		else $error("read strobe got no answer");
	chk_pop_decode: assert property (rx_pop_out |->
		rd_stb_in && addr_in == A_HOLD && !line_control_out[LCR_DIV_BIT])
		else $error("receive pop outside a holding read");
	chk_modem_decode: assert property (msr_read_out |->
		rd_stb_in && addr_in == A_MSTAT && line_control_out != LCR_ENH_KEY)
		else $error("modem read outside its address");
	chk_div_low: assert property (s_div_wr(A_DIV_LO) |=>
		divisor_out[7:0] == $past(wr_data_in))
		else $error("low divisor not written");
	chk_div_high: assert property (s_div_wr(A_DIV_HI) |=>
		divisor_out[15:8] == $past(wr_data_in))
		else $error("high divisor not written");
	chk_char_bank: assert property (wr_stb_in && addr_in == 3'h4 &&
		line_control_out == LCR_ENH_KEY |=> flow_chars_out[7:0] == $past(wr_data_in))
		else $error("flow character not written");
	chk_sleep_gate: assert property (!enhanced_function_out[EFR_ENH_BIT] |->
		!sleep_enable_out)
		else $error("sleep enabled without enhanced bit");
	chk_state_bits: assert property (s_state_rd |=> rd_data_out[LS_DR] ==
		($past(rx_count_in) != 0) && rd_data_out[4:2] == $past(rx_head_err_in) &&
		rd_data_out[LS_FERR] == $past(rx_any_err_in))
		else $error("line state bits wrong");
	chk_mask_gated: assert property (rd_stb_in && addr_in == A_MASK &&
		!line_control_out[LCR_DIV_BIT] && !enhanced_function_out[EFR_ENH_BIT]
		|=> rd_data_out[7:4] == 4'h0)
		else $error("gated mask bits read nonzero");
	chk_gate_outs: assert property (!enhanced_function_out[EFR_ENH_BIT] |->
		(queue_control_out & FCR_GATED) == 8'h00 && (modem_control_out & MCR_GATED) == 8'h00)
		else $error("gated control bits leak");
	chk_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
		tx_valid_out && $stable(tx_data_out))
		else $error("stalled byte not held");
endmodule

bind urie_regmap urie_regmap_props #(.CW(CW)) u_props (
	.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_stb_in(wr_stb_in),
	.rd_stb_in(rd_stb_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
	.rd_valid_out(rd_valid_out), .rx_count_in(rx_count_in),
	.rx_head_err_in(rx_head_err_in), .rx_any_err_in(rx_any_err_in),
	.rx_pop_out(rx_pop_out), .tx_data_out(tx_data_out), .tx_valid_out(tx_valid_out),
	.tx_ready_in(tx_ready_in), .msr_read_out(msr_read_out),
	.line_control_out(line_control_out), .divisor_out(divisor_out),
	.queue_control_out(queue_control_out), .modem_control_out(modem_control_out),
	.enhanced_function_out(enhanced_function_out), .flow_chars_out(flow_chars_out),
	.sleep_enable_out(sleep_enable_out));

`default_nettype wire

// ===== tb/urie_tx_model.sv
// transmitter side model that takes bytes and stalls on request
`timescale 1ns/10ps
`default_nettype none

module urie_tx_model (
	input  wire logic       rst_in,
	input  wire logic       stall_in,
	input  wire logic       valid_in,
	input  wire logic [7:0] data_in,
	output logic            ready_out,
	output logic            take_out,
	output logic [7:0]      take_data_out
);
	// never takes while in reset, so no byte is lost to a reset edge
	assign ready_out = !stall_in && !rst_in;
	assign take_out = valid_in && ready_out;
	assign take_data_out = data_in;
endmodule

`default_nettype wire

// ===== tb/urie_regmap_bench.sv
// self-checking bench for the uart register map
`timescale 1ns/10ps
`default_nettype none

module urie_regmap_bench
	import urie_pkg::*;
;
	localparam logic [7:0] REV = 8'h3C; // arbitrary value
	localparam logic [7:0] IDV = 8'hA7; // arbitrary value
	logic       clk_in, rst_in, wr_stb, rd_stb, rx_push, rx_any_err, sh_empty, stall;
	logic       rd_valid, thr_ready, tx_valid, tx_ready, take, irq, sleep;
	logic [2:0] addr, rx_head_err;
	logic [3:0] rx_push_err;
	logic [6:0] rx_count, tx_count;
	logic [7:0] wr_data, rx_data, modem, rd_data, tx_data, take_data, v, m;
	int         bad_count, tests_run, n;
	logic [7:0] exp_q[$], msk_q[$], txq[$];

	initial begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	urie_regmap #(.REV_CODE(REV), .ID_CODE(IDV), .CW(7)) DUT (
		.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wr_stb_in(wr_stb),
		.rd_stb_in(rd_stb), .wr_data_in(wr_data), .rd_data_out(rd_data),
		.rd_valid_out(rd_valid), .thr_ready_out(thr_ready), .rx_data_in(rx_data),
		.rx_count_in(rx_count), .rx_push_in(rx_push), .rx_push_err_in(rx_push_err),
		.rx_head_err_in(rx_head_err), .rx_any_err_in(rx_any_err), .rx_pop_out(),
		.tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
		.tx_count_in(tx_count), .tx_shift_empty_in(sh_empty), .modem_status_in(modem),
		.msr_read_out(), .irq_out(irq), .line_control_out(), .divisor_out(),
		.queue_control_out(), .modem_control_out(), .enhanced_function_out(),
		.feature_control_out(), .alt_function_out(), .trigger_level_out(),
		.flow_chars_out(), .sleep_enable_out(sleep), .rx_fifo_reset_out(),
		.tx_fifo_reset_out());

	urie_tx_model u_tx (.rst_in(rst_in), .stall_in(stall), .valid_in(tx_valid),
		.data_in(tx_data), .ready_out(tx_ready), .take_out(take),
		.take_data_out(take_data));

	// ----------------------------------------------------------------
	// compare and bus tasks
	// ----------------------------------------------------------------
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t pin %b expected %b", $time, got, exp);
		end
	endtask
	task automatic test_done;
		if (bad_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge clk_in);
		wr_stb <= 1'b0;
	endtask
	// expected value and mask are queued for the read monitor
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] k);
		@(posedge clk_in);
		addr <= a;
		rd_stb <= 1'b1;
		exp_q.push_back(e & k);
		msk_q.push_back(k);
		@(posedge clk_in);
		rd_stb <= 1'b0;
	endtask
	task automatic settle;
		@(negedge clk_in);
	endtask

	always @(posedge clk_in) begin
		if (rd_valid === 1'b1) begin
			m = (msk_q.size() > 0) ? msk_q.pop_front() : 8'hFF;
			chk_byte(rd_data & m, (exp_q.size() > 0) ? exp_q.pop_front() : ~rd_data);
		end
		if (take === 1'b1)
			chk_byte(take_data, (txq.size() > 0) ? txq.pop_front() : ~take_data);
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		v = 8'($urandom(32'h5e769202));
		{wr_stb, rd_stb, rx_push, rx_any_err, stall, addr, rx_head_err} = '0;
		{rx_push_err, rx_count, tx_count, wr_data, rx_data, modem} = '0;
		sh_empty = 1'b1;
		rst_in = 1'b1;
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(A_MASK, 8'h00, 8'hFF);
		rd(A_SRC, 8'h01, 8'hFF);
		wr(A_LINE, 8'h80);
		for (n = 0; n < 2; n++) begin
			v = 8'($urandom) | 8'h01;
			wr(n[2:0], v);
			rd(n[2:0], v, 8'hFF);
		end
		wr(A_DIV_LO, 8'h00);
		wr(A_DIV_HI, 8'h00);
		rd(A_DIV_LO, REV, 8'hFF);
		rd(A_DIV_HI, IDV, 8'hFF);
		rd(A_LINE, 8'h80, 8'hFF);
		wr(A_ALT, 8'h05);
		rd(A_ALT, 8'h05, 8'hFF);
		wr(A_LINE, LCR_ENH_KEY);
		wr(A_ENH, 8'h10);
		for (n = 4; n < 8; n++) begin
			v = 8'($urandom);
			wr(n[2:0], v);
			rd(n[2:0], v, 8'hFF);
		end
		rd(A_ENH, 8'h10, 8'hFF);
		wr(A_FEAT, v);
		rd(A_FEAT, v, 8'hFF);
		wr(A_TRIG, 8'h04);
		wr(A_LINE, 8'h00);
		rd(A_MODEM, 8'h00, 8'hFF);
		wr(A_MODEM, 8'hE0);
		wr(A_MASK, 8'h10);
		rd(A_MASK, 8'h10, 8'hFF);
		settle;
		chk_pin(sleep, 1'b1);
		wr(A_LINE, LCR_ENH_KEY);
		wr(A_ENH, 8'h00);
		wr(A_LINE, 8'h00);
		wr(A_MASK, 8'hF0);
		rd(A_MASK, 8'h00, 8'hFF);
		rd(A_MODEM, 8'h00, 8'hFF);
		settle;
		chk_pin(sleep, 1'b0);
		wr(A_MASK, 8'h01);
		settle;
		chk_pin(irq, 1'b0);
		v = 8'($urandom);
		@(posedge clk_in);
		rx_data <= v;
		rx_count <= 7'd1;
		settle;
		chk_pin(irq, 1'b1);
		rd(A_SRC, 8'h04, 8'hFF);
		rd(A_HOLD, v, 8'hFF);
		wr(A_MASK, 8'h00);
		settle;
		chk_pin(irq, 1'b0);
		// fifo mode, trigger level four
		wr(A_SRC, 8'h01);
		wr(A_MASK, 8'h01);
		rx_count <= 7'd3;
		settle;
		chk_pin(irq, 1'b0);
		@(posedge clk_in);
		rx_count <= 7'd4;
		settle;
		chk_pin(irq, 1'b1);
		rd(A_SRC, 8'hC4, 8'hFF);
		rx_count <= 7'd3;
		settle;
		chk_pin(irq, 1'b0);
		@(posedge clk_in);
		rx_count <= 7'd4;
		wr(A_MASK, 8'h00);
		settle;
		chk_pin(irq, 1'b0);
		rd(A_STATE, 8'h61, 8'hFF);
		rx_count <= 7'd9;
		wr(A_LINE, LCR_ENH_KEY);
		rd(A_TRIG, 8'h09, 8'hFF);
		wr(A_LINE, 8'h00);
		wr(A_MASK, 8'h04);
		@(posedge clk_in);
		rx_push <= 1'b1;
		rx_push_err <= 4'h1;
		rx_head_err <= 3'h5;
		rx_any_err <= 1'b1;
		@(posedge clk_in);
		rx_push <= 1'b0;
		settle;
		chk_pin(irq, 1'b1);
		rd(A_STATE, 8'hF7, 8'hFF);
		settle;
		chk_pin(irq, 1'b0);
		rd(A_STATE, 8'hF5, 8'hFF);
		{rx_head_err, rx_any_err, rx_count} <= '0;
		wr(A_MASK, 8'h02);
		@(posedge clk_in);
		settle;
		chk_pin(irq, 1'b1);
		rd(A_SRC, 8'hC2, 8'hFF);
		settle;
		chk_pin(irq, 1'b0);
		// stalled transmitter: third byte meets a full buffer and is dropped
		stall = 1'b1;
		for (n = 0; n < 3; n++) begin
			v = 8'($urandom);
			wr(A_HOLD, v);
			if (n < 2)
				txq.push_back(v);
		end
		settle;
		chk_pin(thr_ready, 1'b0);
		rd(A_STATE, 8'h00, 8'h60);
		stall <= 1'b0;
		for (n = 0; n < 50 && txq.size() > 0; n++)
			@(posedge clk_in);
		if (txq.size() > 0) begin
			bad_count++;
			test_done;
		end
		repeat (3) @(posedge clk_in);
		settle;
		chk_pin(irq, 1'b1);
		rd(A_SRC, 8'hC2, 8'hFF);
		wr(A_MASK, 8'h08);
		modem <= 8'h01;
		settle;
		chk_pin(irq, 1'b1);
		rd(A_MSTAT, 8'h01, 8'hFF);
		modem <= 8'h00;
		wr(A_MASK, 8'h00);
		settle;
		chk_pin(irq, 1'b0);
		repeat (4) @(posedge clk_in);
		test_done;
	end
endmodule

`default_nettype wire
